// *** testbench/dsc_slot_cap_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// Compare helper: counts every check, reports a mismatch at once
`define CHECK_EQ(what, expv, gotv) begin checked++; if ((gotv) !== (expv)) begin n_mismatch++; \
   $display("wrong value %s expected %h seen %h", what, expv, gotv); end end
module dsc_slot_cap_tb;
   logic                 mclk = 1'b0;
   logic                 sys_rst = 1'b1;
   dsc_pkg::dsc_cfg_wr_t cfgWr = '0;
   logic [11:0]          cfgRdAddr = 12'h000;
   logic [12:0]          slotInfoNum = 13'h0000;
   logic [15:0]          genCtl = 16'h0000;
   logic                 genCtlWr = 1'b0;
   logic                 interlockFittedCtl = 1'b0;
   logic [2:0]           downstreamStrapInputs = 3'h1;
   logic                 eeLoad = 1'b0;
   dsc_pkg::dsc_budget_t eeBudget = '0;
   logic [31:0]          cfgRdData;
   logic                 setSlotPowerLimitReq;
   dsc_pkg::dsc_budget_t powerLimitMsg;
   int                   n_mismatch = 0;
   int                   checked = 0;
   int                   pulseCount = 0;   // Message requests seen so far
   int                   p;
   logic [3:0]           expGc = 4'h0;     // Expected bits 6..3
   logic [9:0]           expBudget = 10'h000;

   dsc_slot_cap DUT (.mclk(mclk), .sys_rst(sys_rst), .cfgWr(cfgWr), .cfgRdAddr(cfgRdAddr),
      .slotInfoNum(slotInfoNum), .genCtl(genCtl), .genCtlWr(genCtlWr), .interlockFittedCtl(interlockFittedCtl),
      .downstreamStrapInputs(downstreamStrapInputs), .eeLoad(eeLoad), .eeBudget(eeBudget),
      .cfgRdData(cfgRdData), .setSlotPowerLimitReq(setSlotPowerLimitReq), .powerLimitMsg(powerLimitMsg));

   ////////////////////////////////////////////////////////////////////////////
   // 8 ns clock
   always #4 mclk = ~mclk;
   // Count one-cycle message pulses; a stuck pulse inflates the count
   always @(posedge mclk) if (setSlotPowerLimitReq === 1'b1) pulseCount++;

   // Expected word built from live sources and the bench's own model
   function automatic logic [31:0] exp_word();
      return {slotInfoNum, interlockFittedCtl, 1'b0, expBudget, expGc, 3'b000};
   endfunction : exp_word

   task automatic rd_check(input logic [11:0] addr, input logic [31:0] expv);
      @(posedge mclk) cfgRdAddr <= addr;
      repeat (2) @(posedge mclk);
      #1;
      `CHECK_EQ("read word", expv, cfgRdData)
   endtask : rd_check

   // Write lasts one cycle, then time for the delayed pulse to land
   task automatic cfg_write(input logic [3:0] be, input logic [31:0] data);
      @(posedge mclk) cfgWr <= '{en: 1'b1, addr: 12'ha4, be: be, data: data};
      @(posedge mclk) cfgWr.en <= 1'b0;
      repeat (4) @(posedge mclk);
   endtask : cfg_write

   task automatic gc_write(input logic [15:0] v);
      @(posedge mclk) begin genCtl <= v; genCtlWr <= 1'b1; end
      @(posedge mclk) genCtlWr <= 1'b0;
      expGc = v[14:11];
   endtask : gc_write

   task automatic do_reset(input logic [2:0] straps, input int cycles);
      @(posedge mclk) begin sys_rst <= 1'b1; downstreamStrapInputs <= straps; end
      repeat (cycles) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (3) @(posedge mclk);
      expGc = {|straps, 1'b1, 2'b00};
      expBudget = 10'h000;
   endtask : do_reset

   task automatic report_and_stop();
      if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog: the sequence needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge mclk);
      n_mismatch++;
      report_and_stop();
   end

   // Main sequence
   initial begin
      do_reset(3'h1, 8);
      rd_check(12'ha4, 32'h0000_0060);
      rd_check(12'ha8, 32'h0000_0000);
      // Walk one control bit at a time through the mirrors
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk) begin interlockFittedCtl <= ~i[0]; slotInfoNum <= 13'h1abc >> i; end
         gc_write(16'h0800 << i);
         rd_check(12'ha4, exp_word());
      end
      // First write takes the budget, mirrored bits stay put
      p = pulseCount;
      cfg_write(4'hf, 32'hffff_ffff);
      expBudget = 10'h3ff;
      `CHECK_EQ("pulses", p + 1, pulseCount)
      `CHECK_EQ("message", 10'h3ff, powerLimitMsg)
      rd_check(12'ha4, exp_word());
      // Second write after reset must be refused
      p = pulseCount;
      cfg_write(4'hf, 32'h0000_0000);
      `CHECK_EQ("pulses", p, pulseCount)
      rd_check(12'ha4, exp_word());
      // EEPROM preload replaces the budget
      @(posedge mclk) begin eeLoad <= 1'b1; eeBudget <= 10'h0b5; end
      @(posedge mclk) eeLoad <= 1'b0;
      expBudget = 10'h0b5;
      rd_check(12'ha4, exp_word());
      // Every scale code, each after its own reset and strap setting
      for (int k = 0; k < 4; k++) begin
         do_reset(k[2:0], 2);
         rd_check(12'ha4, exp_word());
         p = pulseCount;
         cfg_write(4'h9, 32'hffff_ffff);
         `CHECK_EQ("pulses", p, pulseCount)
         cfg_write(k[0] ? 4'h4 : 4'h2, {15'h0000, k[1:0], 8'(k) + 8'h5a, 7'h7f});
         expBudget = {k[1:0], 8'(k) + 8'h5a};
         `CHECK_EQ("pulses", p + 1, pulseCount)
         `CHECK_EQ("message", expBudget, powerLimitMsg)
         rd_check(12'ha4, exp_word());
      end
      report_and_stop();
   end
endmodule : dsc_slot_cap_tb
`default_nettype wire

// *** verilog/dsc_budget_lock.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
// Write-once latch for the power budget fields.
module dsc_budget_lock (
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   input  wire logic               wrHit,
   input  wire logic               eeLoad,
   input  wire dsc_pkg::dsc_budget_t wrBudget,
   input  wire dsc_pkg::dsc_budget_t eeBudget,
   output logic                    sendPulse,
   output dsc_pkg::dsc_budget_t    budget
);
   logic usedReg;     // Software already wrote once since reset
   logic acceptWr;    // This write is the first one

   assign acceptWr = wrHit && !usedReg;   // [R5]

   ////////////////////////////////////////////////////////////////
   // Field storage; reset clears, EEPROM preload then software once
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         budget    <= '{scale: dsc_pkg::dsc_scale_t'(`DSC_SCALE_RESET), value: `DSC_VALUE_RESET}; // [R7]
         usedReg   <= 1'b0;
         sendPulse <= 1'b0;
      end else begin
         sendPulse <= acceptWr;           // [R6]
         if (acceptWr) begin
            budget  <= wrBudget;          // [R4] [R8]
            usedReg <= 1'b1;              // [R5]
         end else if (eeLoad) begin
            // Preload does not spend the software write
            budget  <= eeBudget;          // [R7]
         end
      end
   end

   a_once_only: assert property (@(posedge mclk) disable iff (sys_rst)   // [R5]
      usedReg && wrHit |=> $stable(budget) || $past(eeLoad))
      else $error("budget changed by second write");
   a_send_msg: assert property (@(posedge mclk) disable iff (sys_rst)   // [R6]
      acceptWr |=> sendPulse ##1 (!sendPulse || acceptWr))
      else $error("no message after first write");
endmodule : dsc_budget_lock
`default_nettype wire

// *** verilog/dsc_cfg.svh ***
`ifndef DSC_CFG_SVH
`define DSC_CFG_SVH
// Configuration offset of the slot capability word
`define DSC_SLOT_CAP_OFFSET   12'ha4
// Reset image of the slot capability word
`define DSC_SLOT_CAP_RESET    32'h0000_0060
// Field positions
`define DSC_SLOT_NUM_HI       31
`define DSC_SLOT_NUM_LO       19
`define DSC_INTERLOCK_BIT     18
`define DSC_NO_CMD_DONE_BIT   17
`define DSC_SCALE_HI          16
`define DSC_SCALE_LO          15
`define DSC_VALUE_HI          14
`define DSC_VALUE_LO          7
`define DSC_HOT_SWAP_BIT      6
`define DSC_UNANNOUNCED_BIT   5
`define DSC_POWER_LAMP_BIT    4
`define DSC_ATTN_LAMP_BIT     3
// General control source bit positions
`define DSC_GC_HOT_SWAP_BIT   14
`define DSC_GC_UNANNOUNCED_BIT 13
`define DSC_GC_POWER_LAMP_BIT 12
`define DSC_GC_ATTN_LAMP_BIT  11
// Reset values of the power budget fields
`define DSC_SCALE_RESET       2'h0
`define DSC_VALUE_RESET       8'h00
`endif

// *** verilog/dsc_pkg.sv ***
`default_nettype none
package dsc_pkg;
   // Power budget scale codes
   typedef enum logic [1:0] {
      DSC_SCALE_1      = 2'b00,
      DSC_SCALE_0P1    = 2'b01,
      DSC_SCALE_0P01   = 2'b10,
      DSC_SCALE_0P001  = 2'b11
   } dsc_scale_t;
   // Power budget carried to the message generator
   typedef struct packed {
      dsc_scale_t  scale;
      logic [7:0]  value;
   } dsc_budget_t;
   // Configuration write request
   typedef struct packed {
      logic        en;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] data;
   } dsc_cfg_wr_t;
endpackage : dsc_pkg
`default_nettype wire

// *** verilog/dsc_slot_cap.sv ***
// Overview of operation
// R1: Slot number field mirrors slot info register
// R2: Interlock bit mirrors general control setting
// R3: No-command-done bit always reads zero
// R4: Two-bit power scale stored, four multipliers
// R5: Power fields writable once per reset
// R6: Field write sends power limit message
// R7: Reset clears fields, EEPROM then loads
// R8: Eight-bit power value stored
// R9: Hot-swap bit from straps, then control
// R10: Unannounced removal mirrors control bit 13
// R11: Power lamp bit mirrors control bit 12
// R12: Attention lamp mirrors control bit 11
// R13: Register sits at offset a4
// R14: Reset value reads 0000_0060
// R15: Writes to mirrored fields are ignored
`timescale 1ns/1ps
`default_nettype none
`include "dsc_cfg.svh"
module dsc_slot_cap #(
   parameter int SLOT_NUM_W = 13     // Slot number width
) (
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   input  wire dsc_pkg::dsc_cfg_wr_t  cfgWr,
   input  wire logic [11:0]           cfgRdAddr,
   input  wire logic [SLOT_NUM_W-1:0] slotInfoNum,
   input  wire logic [15:0]           genCtl,
   input  wire logic                  genCtlWr,
   input  wire logic                  interlockFittedCtl,
   input  wire logic [2:0]            downstreamStrapInputs,
   input  wire logic                  eeLoad,
   input  wire dsc_pkg::dsc_budget_t  eeBudget,
   output logic [31:0]                cfgRdData,
   output logic                       setSlotPowerLimitReq,
   output dsc_pkg::dsc_budget_t       powerLimitMsg
);
   ////////////////////////////////////////////////////////////////
   // Decode
   wire       capHit = cfgRdAddr == `DSC_SLOT_CAP_OFFSET;          // [R13]
   wire       wrHit  = cfgWr.en && cfgWr.addr == `DSC_SLOT_CAP_OFFSET
                       && (cfgWr.be[1] || cfgWr.be[2]);            // [R13]
   // Budget fields span bits 16 to 7, across byte lanes 0, 1 and 2
   wire dsc_pkg::dsc_budget_t wrBudget = cfgWr.data[`DSC_SCALE_HI:`DSC_VALUE_LO];

   logic                  hotSwapReg;        // Hot-swap capable mirror
   logic                  unannouncedReg;    // Surprise removal mirror
   logic                  powerLampReg;      // Power indicator mirror
   logic                  attnLampReg;       // Attention indicator mirror
   logic                  strapTakenReg;     // Straps sampled after reset
   logic                  sendPulse;         // First budget write seen
   dsc_pkg::dsc_budget_t  budget;            // Live power budget
   logic [31:0]           capWord;           // Assembled register image
   logic                  msgSentReg;        // A message already left since reset
   // Reset image as a named constant so single bits can be picked from it;
   // lamps and removal bits then follow the image without separate numbers
   // Mirrors sit in flops, so a control write shows on the next read only
   localparam logic [31:0] CAP_RESET = `DSC_SLOT_CAP_RESET;              // [R14]

   ////////////////////////////////////////////////////////////////
   // Mirror bits; reset gives 0060, straps then control register
   // Strap taken one cycle after release, never under reset itself
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         // Single bits of the reset image; lamps read zero after reset
         hotSwapReg     <= CAP_RESET[`DSC_HOT_SWAP_BIT];       // [R14]
         unannouncedReg <= CAP_RESET[`DSC_UNANNOUNCED_BIT];    // [R14]
         powerLampReg   <= CAP_RESET[`DSC_POWER_LAMP_BIT];     // [R14]
         attnLampReg    <= CAP_RESET[`DSC_ATTN_LAMP_BIT];      // [R14]
         strapTakenReg  <= 1'b0;
      end else if (genCtlWr) begin
         // Only the control register and, for hot-swap, the straps move these; cfg writes cannot [R15]
         hotSwapReg     <= genCtl[`DSC_GC_HOT_SWAP_BIT];        // [R9]
         unannouncedReg <= genCtl[`DSC_GC_UNANNOUNCED_BIT];     // [R10]
         powerLampReg   <= genCtl[`DSC_GC_POWER_LAMP_BIT];      // [R11]
         attnLampReg    <= genCtl[`DSC_GC_ATTN_LAMP_BIT];       // [R12]
         strapTakenReg  <= 1'b1;
      end else if (!strapTakenReg) begin
         hotSwapReg     <= |downstreamStrapInputs;              // [R9]
         strapTakenReg  <= 1'b1;
      end
   end

   dsc_budget_lock u_lock (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .wrHit     (wrHit),
      .eeLoad    (eeLoad),
      .wrBudget  (wrBudget),
      .eeBudget  (eeBudget),
      .sendPulse (sendPulse),
      .budget    (budget)
   );

   ////////////////////////////////////////////////////////////////
   // Register image
   // Configuration writes reach this image only through the lock,
   // so mirrored fields cannot be changed from the bus side
   always_comb begin
      capWord = 32'h0000_0000;
      capWord[`DSC_SLOT_NUM_HI:`DSC_SLOT_NUM_LO] = slotInfoNum;     // [R1]
      capWord[`DSC_INTERLOCK_BIT]   = interlockFittedCtl;           // [R2]
      capWord[`DSC_NO_CMD_DONE_BIT] = 1'b0;                         // [R3]
      capWord[`DSC_SCALE_HI:`DSC_VALUE_LO] = budget;                // [R4] [R8]
      capWord[`DSC_HOT_SWAP_BIT]    = hotSwapReg;
      capWord[`DSC_UNANNOUNCED_BIT] = unannouncedReg;
      capWord[`DSC_POWER_LAMP_BIT]  = powerLampReg;
      capWord[`DSC_ATTN_LAMP_BIT]   = attnLampReg;
   end

   // Read selection; any other offset reads as zero, so a stray probe
   // of a neighbouring register cannot alias this word
   wire [31:0] rdNext = capHit ? capWord : 32'h0000_0000;             // [R13]

   ////////////////////////////////////////////////////////////////
   // Registered outputs; unmapped reads return zero
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cfgRdData            <= 32'h0000_0000;
         setSlotPowerLimitReq <= 1'b0;
         powerLimitMsg        <= '0;
      end else begin
         cfgRdData            <= rdNext;                             // [R13]
         setSlotPowerLimitReq <= sendPulse;                          // [R6]
         powerLimitMsg        <= budget;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Checker helper: one message per reset is all that write-once allows
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         msgSentReg <= 1'b0;
      end else if (setSlotPowerLimitReq) begin
         msgSentReg <= 1'b1;                                      // [R5]
      end
   end

   ////////////////////////////////////////////////////////////////
   // Named steps of reset and of the budget write
   // Reset seen on two edges in a row: flops now hold the reset image
   sequence s_reset_held;
      sys_rst ##1 sys_rst;
   endsequence
   // First free cycle after reset with no control write competing;
   // this is the one cycle in which the straps are taken
   sequence s_reset_released;
      sys_rst ##1 (!sys_rst && !genCtlWr);
   endsequence
   // Write on the bus, then the lock reports it as the accepted one
   sequence s_budget_taken;
      wrHit ##1 sendPulse;
   endsequence
   // Request raised with the budget that stood one cycle before
   sequence s_msg_raised;
      setSlotPowerLimitReq && powerLimitMsg == $past(budget);
   endsequence

   ////////////////////////////////////////////////////////////////
   // Register image checks
   a_no_cmd_done: assert property (@(posedge mclk) disable iff (sys_rst)   // [R3]
      capHit |=> !cfgRdData[`DSC_NO_CMD_DONE_BIT])
      else $error("no-command-done bit read as one");
   a_slot_num: assert property (@(posedge mclk) disable iff (sys_rst)   // [R1]
      capHit |=> cfgRdData[`DSC_SLOT_NUM_HI:`DSC_SLOT_NUM_LO] == $past(slotInfoNum))
      else $error("slot number mismatch");
   // Interlock is shown live, so the read carries the setting of the cycle before
   a_interlock_live: assert property (@(posedge mclk) disable iff (sys_rst)   // [R2]
      capHit |=> cfgRdData[`DSC_INTERLOCK_BIT] == $past(interlockFittedCtl))
      else $error("interlock bit mismatch");
   a_budget_image: assert property (@(posedge mclk) disable iff (sys_rst)   // [R4] [R8]
      capHit |=> cfgRdData[`DSC_SCALE_HI:`DSC_VALUE_LO] == $past(budget))
      else $error("power budget field mismatch");
   a_unmapped_zero: assert property (@(posedge mclk) disable iff (sys_rst)   // [R13]
      !capHit |=> cfgRdData == 32'h0000_0000)
      else $error("unmapped read not zero");

   ////////////////////////////////////////////////////////////////
   // Mirror checks
   a_gc_mirror: assert property (@(posedge mclk) disable iff (sys_rst)   // [R9] [R12]
      genCtlWr |=> hotSwapReg == $past(genCtl[`DSC_GC_HOT_SWAP_BIT])
                   && attnLampReg == $past(genCtl[`DSC_GC_ATTN_LAMP_BIT]))
      else $error("control mirror not updated");
   a_gc_lamps: assert property (@(posedge mclk) disable iff (sys_rst)   // [R10] [R11]
      genCtlWr |=> unannouncedReg == $past(genCtl[`DSC_GC_UNANNOUNCED_BIT])
                   && powerLampReg == $past(genCtl[`DSC_GC_POWER_LAMP_BIT]))
      else $error("removal or power lamp mirror not updated");
   // Straps set the hot-swap default only in the first free cycle
   a_strap_default: assert property (@(posedge mclk)   // [R9]
      s_reset_released |=> sys_rst || hotSwapReg == $past(|downstreamStrapInputs))
      else $error("hot-swap default not taken from straps");
   a_ro_ignore: assert property (@(posedge mclk) disable iff (sys_rst)   // [R15]
      wrHit && !genCtlWr && strapTakenReg |=> $stable(powerLampReg) && $stable(attnLampReg)
                                             && $stable(hotSwapReg) && $stable(unannouncedReg))
      else $error("mirror moved by cfg write");

   ////////////////////////////////////////////////////////////////
   // Reset and power budget message checks
   // Sequence form keeps the check off the first edge, where flops are unknown
   a_reset_image: assert property (@(posedge mclk)   // [R14] [R7]
      s_reset_held |-> hotSwapReg && unannouncedReg && !powerLampReg && !attnLampReg && budget == '0)
      else $error("reset image wrong");
   a_msg_follow: assert property (@(posedge mclk) disable iff (sys_rst)   // [R6]
      sendPulse |=> setSlotPowerLimitReq && powerLimitMsg == $past(budget))
      else $error("power limit message missing");
   // Accepted write, then the request two cycles on with that very budget
   a_msg_chain: assert property (@(posedge mclk) disable iff (sys_rst)   // [R6]
      s_budget_taken |=> s_msg_raised)
      else $error("power limit request not chained to write");
   a_msg_data: assert property (@(posedge mclk) disable iff (sys_rst)   // [R4] [R8]
      s_budget_taken |-> budget == $past(wrBudget))
      else $error("budget differs from written data");
   a_no_stray_msg: assert property (@(posedge mclk) disable iff (sys_rst)   // [R6]
      !wrHit |=> !sendPulse)
      else $error("message without a write");
   // Second request in one reset period would mean a second write got in
   a_one_msg: assert property (@(posedge mclk) disable iff (sys_rst)   // [R5]
      msgSentReg |-> !setSlotPowerLimitReq)
      else $error("second power limit message");
   a_pulse_once: assert property (@(posedge mclk) disable iff (sys_rst)   // [R6]
      setSlotPowerLimitReq |=> !setSlotPowerLimitReq)
      else $error("power limit request longer than one cycle");
endmodule : dsc_slot_cap
`default_nettype wire
